// >>> core/mpf_pkg.sv
// constants shared by the management and flow control register slice
package mpf_pkg;
  // ----------------------------------------
  // register offsets (byte addresses)
  // ----------------------------------------
  localparam int MPF_ADDR_W = 12;
  localparam logic [11:0] MPF_OFS_CMD = 12'h114;
  localparam logic [11:0] MPF_OFS_DATA = 12'h118;
  localparam logic [11:0] MPF_OFS_FLOW = 12'h11C;
  // ----------------------------------------
  // field positions
  // ----------------------------------------
  localparam int MPF_CMD_BUSY = 0;
  localparam int MPF_CMD_WSEL = 1;
  localparam int MPF_CMD_REG_LSB = 6;
  localparam int MPF_CMD_PHY_LSB = 11;
  localparam int MPF_FLOW_BUSY = 0;
  localparam int MPF_FLOW_EN = 1;
  localparam int MPF_FLOW_PASS = 2;
  localparam int MPF_FLOW_PT_LSB = 16;
  // ----------------------------------------
  // reset values
  // ----------------------------------------
  localparam logic [4:0] MPF_RST_PHY = 5'h00;
  localparam logic [4:0] MPF_RST_REG = 5'h00;
  localparam logic [15:0] MPF_RST_DATA = 16'h0000;
  localparam logic [15:0] MPF_RST_PT = 16'h0000;
  // ----------------------------------------
  // timing
  // ----------------------------------------
  localparam int MPF_CLK_KHZ = 100000;
  localparam int MPF_MDC_KHZ = 2500;
  localparam int MPF_MDC_HALF = MPF_CLK_KHZ / (2 * MPF_MDC_KHZ);
  // ----------------------------------------
  // management frame layout, msb sent first
  // ----------------------------------------
  localparam int MPF_FRAME_BITS = 64;
  localparam int MPF_TA_IDX = 46;
  localparam int MPF_DATA_IDX = 48;
  localparam logic [31:0] MPF_PREAMBLE = 32'hFFFFFFFF;
  localparam logic [1:0] MPF_ST = 2'h1;
  localparam logic [1:0] MPF_OP_RD = 2'h2;
  localparam logic [1:0] MPF_OP_WR = 2'h1;
  localparam logic [1:0] MPF_TA_WR = 2'h2;
  // ----------------------------------------
  // pause frame fields
  // ----------------------------------------
  localparam logic [47:0] MPF_PAUSE_DA = 48'h0180C2000001;
  localparam logic [15:0] MPF_CTRL_TYPE = 16'h8808;
  localparam logic [15:0] MPF_PAUSE_OP = 16'h0001;
  typedef enum logic [0:0] {MPF_IDLE, MPF_SHIFT} mpf_state_type;
endpackage

// >>> core/mpf_regs.sv
// phy management and flow control registers of the mac
`timescale 1ns/1ps
`default_nettype none
module mpf_regs
  import mpf_pkg::*;
#(
  parameter int MDC_HALF = MPF_MDC_HALF
)
(
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic [11:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  output logic mdc,
  output logic mdio_out,
  output logic mdio_oe,
  input wire logic mdio_in,
  input wire logic full_duplex,
  input wire logic tx_ctrl_done,
  output logic tx_ctrl_req,
  output logic [47:0] tx_ctrl_dest,
  output logic [15:0] tx_ctrl_type,
  output logic [15:0] tx_ctrl_opcode,
  output logic [15:0] tx_ctrl_time,
  output logic back_pressure,
  input wire logic rx_frame_end,
  input wire logic rx_is_pause,
  input wire logic rx_frame_ok,
  input wire logic rx_filter_force,
  input wire logic rx_addr_pass,
  output logic rx_status_valid,
  output logic rx_pkt_filter,
  output logic rx_pause_apply,
  output logic [15:0] rx_pause_quanta,
  input wire logic [15:0] rx_pause_field
);
  // ----------------------------------------
  // reset release and pin synchroniser
  // ----------------------------------------
  logic [1:0] rst_sync;
  logic rst_n;
  logic [2:0] mdio_sync;
  logic mdio_filt;

  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
      rst_sync <= 2'h0;
    else
      rst_sync <= {rst_sync[0], 1'b1};
  end
  assign rst_n = rst_sync[1];

  // glitch filter: only second and third stage are compared
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      mdio_sync <= 3'h7;
      mdio_filt <= 1'b1;
    end
    else
    begin
      mdio_sync <= {mdio_sync[1:0], mdio_in};
      if (mdio_sync[1] == mdio_sync[2])
        mdio_filt <= mdio_sync[2];
    end
  end

  // ----------------------------------------
  // register state
  // ----------------------------------------
  mpf_state_type state;
  logic [4:0] phy_addr;
  logic [4:0] phy_reg_index;
  logic phy_write_select;
  logic phy_access_busy;
  logic [15:0] mgmt_data;
  logic [15:0] pause_time_value;
  logic pass_ctrl_frames;
  logic flow_ctrl_enable;
  logic pause_busy;
  logic [63:0] frm;
  logic [15:0] rd_shift;
  logic [5:0] bit_idx;
  logic [7:0] div_cnt;

  // ----------------------------------------
  // address decode
  // ----------------------------------------
  wire hit_cmd = reg_addr == MPF_OFS_CMD;
  wire hit_data = reg_addr == MPF_OFS_DATA;
  wire hit_flow = reg_addr == MPF_OFS_FLOW;
  wire cmd_start = reg_wr && hit_cmd && !phy_access_busy
    && reg_wdata[MPF_CMD_BUSY];
  wire flow_busy = pause_busy | back_pressure;
  wire flow_start = reg_wr && hit_flow && !flow_busy
    && reg_wdata[MPF_FLOW_BUSY];
  wire [4:0] wr_reg = reg_wdata[MPF_CMD_REG_LSB +: 5];
  wire [4:0] wr_phy = reg_wdata[MPF_CMD_PHY_LSB +: 5];
  wire wr_sel = reg_wdata[MPF_CMD_WSEL];
  wire [63:0] new_frm = {MPF_PREAMBLE, MPF_ST,
    wr_sel ? MPF_OP_WR : MPF_OP_RD, wr_phy, wr_reg,
    MPF_TA_WR, mgmt_data};
  wire [31:0] cmd_view = {16'h0000, phy_addr, phy_reg_index, 4'h0,
    phy_write_select, phy_access_busy};
  wire [31:0] flow_view = {pause_time_value, 13'h0000,
    pass_ctrl_frames, flow_ctrl_enable, flow_busy};
  wire [31:0] rd_mux = hit_cmd ? cmd_view
    : hit_data ? {16'h0000, mgmt_data}
    : hit_flow ? flow_view : 32'h00000000;

  // ----------------------------------------
  // management clock phases
  // ----------------------------------------
  wire tick = div_cnt == 8'(MDC_HALF - 1);
  wire fall = tick && mdc;
  wire rise = tick && !mdc;
  wire last_bit = bit_idx == 6'(MPF_FRAME_BITS - 1);
  wire done = fall && last_bit;
  wire rd_phase = !phy_write_select
    && bit_idx >= 6'(MPF_TA_IDX);

  // ----------------------------------------
  // bus slave: read data the cycle after the strobe
  // ----------------------------------------
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      reg_rdata <= 32'h00000000;
    else
      reg_rdata <= reg_rd ? rd_mux : 32'h00000000;
  end

  // ----------------------------------------
  // command and data registers
  // ----------------------------------------
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      phy_addr <= MPF_RST_PHY;
      phy_reg_index <= MPF_RST_REG;
      phy_write_select <= 1'b0;
      mgmt_data <= MPF_RST_DATA;
    end
    else
    begin
      // writes during an access are dropped to protect the frame
      if (reg_wr && hit_cmd && !phy_access_busy)
      begin
        phy_addr <= wr_phy;
        phy_reg_index <= wr_reg;
        phy_write_select <= wr_sel;
      end
      if (reg_wr && hit_data && !phy_access_busy)
        mgmt_data <= reg_wdata[15:0];
      else if (done && !phy_write_select)
        mgmt_data <= rd_shift;
    end
  end

  // ----------------------------------------
  // management frame engine
  // ----------------------------------------
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state <= MPF_IDLE;
      phy_access_busy <= 1'b0;
      frm <= 64'h0000000000000000;
      rd_shift <= 16'h0000;
      bit_idx <= 6'h00;
      div_cnt <= 8'h00;
      mdc <= 1'b0;
      mdio_out <= 1'b0;
      mdio_oe <= 1'b0;
    end
    else
    begin
      case (state)
        MPF_IDLE:
        begin
          if (cmd_start)
          begin
            state <= MPF_SHIFT;
            phy_access_busy <= 1'b1;
            frm <= new_frm;
            bit_idx <= 6'h00;
            div_cnt <= 8'h00;
            mdio_out <= new_frm[63];
            mdio_oe <= 1'b1;
          end
        end
        MPF_SHIFT:
        begin
          div_cnt <= tick ? 8'h00 : div_cnt + 8'h01;
          if (tick)
            mdc <= !mdc;
          if (rise && bit_idx >= 6'(MPF_DATA_IDX))
            rd_shift <= {rd_shift[14:0], mdio_filt};
          if (done)
          begin
            state <= MPF_IDLE;
            phy_access_busy <= 1'b0;
            mdio_oe <= 1'b0;
            mdio_out <= 1'b0;
          end
          else if (fall)
          begin
            bit_idx <= bit_idx + 6'h01;
            frm <= {frm[62:0], 1'b0};
            mdio_out <= frm[62];
            // turnaround and data belong to the phy on a read
            mdio_oe <= !(!phy_write_select
              && bit_idx + 6'h01 >= 6'(MPF_TA_IDX));
          end
        end
        default:
          state <= MPF_IDLE;
      endcase
    end
  end

  // ----------------------------------------
  // flow control transmit side
  // ----------------------------------------
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pause_time_value <= MPF_RST_PT;
      pass_ctrl_frames <= 1'b0;
      flow_ctrl_enable <= 1'b0;
      pause_busy <= 1'b0;
      tx_ctrl_req <= 1'b0;
      tx_ctrl_dest <= 48'h000000000000;
      tx_ctrl_type <= 16'h0000;
      tx_ctrl_opcode <= 16'h0000;
      tx_ctrl_time <= 16'h0000;
      back_pressure <= 1'b0;
    end
    else
    begin
      if (reg_wr && hit_flow && !flow_busy)
      begin
        pause_time_value <= reg_wdata[MPF_FLOW_PT_LSB +: 16];
        pass_ctrl_frames <= reg_wdata[MPF_FLOW_PASS];
        flow_ctrl_enable <= reg_wdata[MPF_FLOW_EN];
      end
      // a new request wins over a completion in the same cycle
      if (flow_start)
      begin
        pause_busy <= 1'b1;
        tx_ctrl_req <= 1'b1;
        tx_ctrl_dest <= MPF_PAUSE_DA;
        tx_ctrl_type <= MPF_CTRL_TYPE;
        tx_ctrl_opcode <= MPF_PAUSE_OP;
        tx_ctrl_time <= reg_wdata[MPF_FLOW_PT_LSB +: 16];
      end
      else if (tx_ctrl_done)
      begin
        pause_busy <= 1'b0;
        tx_ctrl_req <= 1'b0;
      end
      back_pressure <= flow_ctrl_enable && !full_duplex;
    end
  end

  // ----------------------------------------
  // flow control receive side
  // ----------------------------------------
  wire pause_ok = rx_is_pause && rx_frame_ok;
  wire filt_flag = rx_filter_force ? rx_addr_pass
    : pause_ok ? pass_ctrl_frames : rx_addr_pass;

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rx_status_valid <= 1'b0;
      rx_pkt_filter <= 1'b0;
      rx_pause_apply <= 1'b0;
      rx_pause_quanta <= 16'h0000;
    end
    else
    begin
      rx_status_valid <= rx_frame_end;
      rx_pkt_filter <= rx_frame_end && filt_flag;
      rx_pause_apply <= rx_frame_end && pause_ok && full_duplex
        && flow_ctrl_enable;
      if (rx_frame_end && pause_ok)
        rx_pause_quanta <= rx_pause_field;
    end
  end

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  sequence s_cmd_start;
    reg_wr && hit_cmd && reg_wdata[MPF_CMD_BUSY] && !phy_access_busy;
  endsequence

  property p_busy_set;
    @(posedge core_clk) disable iff (!rst_n)
    s_cmd_start |=> phy_access_busy && mdio_oe;
  endproperty
  a_busy_set: assert property (p_busy_set)
    else $error("busy not set on start");

  property p_busy_hold;
    @(posedge core_clk) disable iff (!rst_n)
    phy_access_busy && !done |=> phy_access_busy;
  endproperty
  a_busy_hold: assert property (p_busy_hold)
    else $error("busy dropped early");

  property p_reg_field;
    @(posedge core_clk) disable iff (!rst_n)
    s_cmd_start |=> frm[22:18] == phy_reg_index
      && frm[27:23] == phy_addr;
  endproperty
  a_reg_field: assert property (p_reg_field)
    else $error("frame register field wrong");

  property p_read_release;
    @(posedge core_clk) disable iff (!rst_n)
    phy_access_busy && rd_phase && bit_idx > 6'(MPF_TA_IDX)
      |-> !mdio_oe;
  endproperty
  a_read_release: assert property (p_read_release)
    else $error("driving pin during read data");

  property p_read_data;
    @(posedge core_clk) disable iff (!rst_n)
    $fell(phy_access_busy) && !phy_write_select
      |-> mgmt_data == $past(rd_shift);
  endproperty
  a_read_data: assert property (p_read_data)
    else $error("read word not captured");

  property p_rdata;
    @(posedge core_clk) disable iff (!rst_n)
    reg_rd && hit_data |=> reg_rdata == {16'h0000, $past(mgmt_data)};
  endproperty
  a_rdata: assert property (p_rdata)
    else $error("data word readback wrong");

  property p_pause_req;
    @(posedge core_clk) disable iff (!rst_n)
    flow_start |=> tx_ctrl_req && pause_busy
      && tx_ctrl_time == $past(reg_wdata[31:16]);
  endproperty
  a_pause_req: assert property (p_pause_req)
    else $error("pause request missing");

  property p_flow_clear;
    @(posedge core_clk) disable iff (!rst_n)
    pause_busy && tx_ctrl_done && !flow_start |=> !pause_busy;
  endproperty
  a_flow_clear: assert property (p_flow_clear)
    else $error("flow busy stuck");

  property p_pause_apply;
    @(posedge core_clk) disable iff (!rst_n)
    rx_pause_apply |-> $past(full_duplex) && $past(flow_ctrl_enable);
  endproperty
  a_pause_apply: assert property (p_pause_apply)
    else $error("pause applied when not allowed");

  property p_filter_flag;
    @(posedge core_clk) disable iff (!rst_n)
    rx_frame_end && pause_ok && !rx_filter_force
      |=> rx_status_valid && rx_pkt_filter == $past(pass_ctrl_frames);
  endproperty
  a_filter_flag: assert property (p_filter_flag)
    else $error("packet filter flag wrong");

  property p_back_pressure;
    @(posedge core_clk) disable iff (!rst_n)
    flow_ctrl_enable && !full_duplex |=> back_pressure;
  endproperty
  a_back_pressure: assert property (p_back_pressure)
    else $error("no back pressure in half duplex");
endmodule
`default_nettype wire

// >>> tb/mpf_phy_model.sv
// behavioural phy management slave facing the register slice
`timescale 1ns/1ps
`default_nettype none
module mpf_phy_model
  import mpf_pkg::*;
(
  input wire logic mdc,
  input wire logic mdio_out,
  input wire logic mdio_oe,
  output logic mdio_in,
  output logic [4:0] last_phy,
  output logic last_wr
);
  logic [15:0] mem [32];
  logic [15:0] sr;
  logic [4:0] ridx;
  logic prev;
  logic drv_oe;
  logic drv_bit;
  int idx;
  // ----------------------------------------
  // wire level, pull-up when nobody drives
  // ----------------------------------------
  assign mdio_in = mdio_oe ? mdio_out : (drv_oe ? drv_bit : 1'b1);
  initial
  begin
    for (int i = 0; i < 32; i++)
      mem[i] = 16'hC000 | 16'(i);
    idx = 0;
    prev = 1'b0;
    drv_oe = 1'b0;
    drv_bit = 1'b0;
    sr = 16'h0000;
  end
  // frame decode; bits counted on rising mdc, drive just after it
  always @(posedge mdc)
  begin
    if (idx == 0)
    begin
      if (mdio_oe && prev && !mdio_out)
        idx = 33;
      prev = mdio_oe & mdio_out;
    end
    else
    begin
      sr = {sr[14:0], mdio_in};
      if (idx == 35)
        last_wr = (sr[1:0] === MPF_OP_WR);
      if (idx == 40)
        last_phy = sr[4:0];
      if (idx == 45)
        ridx = sr[4:0];
      if (idx == 46 && !last_wr)
      begin
        drv_oe = 1'b1;
        drv_bit = 1'b0;
      end
      if (idx >= 47 && idx < 63 && !last_wr)
        drv_bit = mem[ridx][62 - idx];
      if (idx == 63)
      begin
        if (last_wr)
          mem[ridx] = sr;
        drv_oe = 1'b0;
        prev = 1'b0;
        idx = 0;
      end
      else
        idx++;
    end
  end
endmodule
`default_nettype wire

// >>> tb/tb_mpf_regs.sv
// self-checking bench for the management and flow control registers
`timescale 1ns/1ps
`default_nettype none
module tb_mpf_regs import mpf_pkg::*;;
  logic core_clk, nrst, reg_wr, reg_rd, mdio_in, full_duplex;
  logic tx_ctrl_done, rx_frame_end, rx_is_pause, rx_frame_ok;
  logic rx_filter_force, rx_addr_pass, mdc, mdio_out, mdio_oe;
  logic tx_ctrl_req, back_pressure, rx_status_valid, rx_pkt_filter;
  logic rx_pause_apply, phy_wr;
  logic [4:0] phy_addr;
  logic [11:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata, rd;
  logic [15:0] rx_pause_field, tx_ctrl_type, tx_ctrl_opcode;
  logic [15:0] tx_ctrl_time, rx_pause_quanta;
  logic [47:0] tx_ctrl_dest;
  logic [8:0] rx_tab [6];
  int err_count, checked, cycles, n_hi;
  // short mdc half period keeps frames brief; >=5 covers mdio sync
  mpf_regs #(.MDC_HALF(5)) dut (.core_clk(core_clk), .nrst(nrst),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .mdc(mdc),
    .mdio_out(mdio_out), .mdio_oe(mdio_oe), .mdio_in(mdio_in),
    .full_duplex(full_duplex), .tx_ctrl_done(tx_ctrl_done),
    .tx_ctrl_req(tx_ctrl_req), .tx_ctrl_dest(tx_ctrl_dest),
    .tx_ctrl_type(tx_ctrl_type), .tx_ctrl_opcode(tx_ctrl_opcode),
    .tx_ctrl_time(tx_ctrl_time), .back_pressure(back_pressure),
    .rx_frame_end(rx_frame_end), .rx_is_pause(rx_is_pause),
    .rx_frame_ok(rx_frame_ok), .rx_filter_force(rx_filter_force),
    .rx_addr_pass(rx_addr_pass), .rx_status_valid(rx_status_valid),
    .rx_pkt_filter(rx_pkt_filter), .rx_pause_apply(rx_pause_apply),
    .rx_pause_quanta(rx_pause_quanta), .rx_pause_field(rx_pause_field));
  mpf_phy_model phy (.mdc(mdc), .mdio_out(mdio_out), .mdio_oe(mdio_oe),
    .mdio_in(mdio_in), .last_phy(phy_addr), .last_wr(phy_wr));
  // ----------------------------------------
  // clock, timeout and reporting
  // ----------------------------------------
  initial
  begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  always @(posedge core_clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 8000)
    begin
      err_count++;
      close_out();
    end
  end
  task automatic close_out();
    $display("checks %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic chk_pin(input string what, input logic [47:0] exp, got);
    checked++;
    if (got !== exp)
    begin
      err_count++;
      $display("unexpected %s expected %h seen %h", what, exp, got);
    end
  endtask
  // ----------------------------------------
  // register bus
  // ----------------------------------------
  task automatic bus_wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge core_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic bus_rd(input logic [11:0] a);
    @(posedge core_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1;
    rd = reg_rdata;
  endtask
  task automatic chk_reg(input logic [11:0] a, input logic [31:0] exp);
    bus_rd(a);
    chk_pin($sformatf("reg %h", a), 48'(exp), 48'(rd));
  endtask
  task automatic phy_cmd(input logic [4:0] r, input logic w);
    bus_wr(MPF_OFS_CMD, {16'h0000, 5'h01, r, 4'h0, w, 1'b1});
  endtask
  task automatic wait_idle();
    int n;
    n = 0;
    bus_rd(MPF_OFS_CMD);
    while (rd[0] !== 1'b0 && n < 600)
    begin
      bus_rd(MPF_OFS_CMD);
      n++;
    end
    chk_pin("cmd busy", 48'h0, 48'(rd[0]));
  endtask
  // c: pass en fd force addr_pass pause ok; e: filter apply
  task automatic rx_case(input logic [8:0] t, input int i);
    logic bp;
    bp = t[7] & !t[6];
    bus_wr(MPF_OFS_FLOW, {29'h0, t[8], t[7], 1'b0});
    @(posedge core_clk);
    full_duplex <= t[6];
    rx_filter_force <= t[5];
    rx_addr_pass <= t[4];
    rx_is_pause <= t[3];
    rx_frame_ok <= t[2];
    rx_pause_field <= 16'(16'h0040 + i);
    repeat (2) @(posedge core_clk);
    #1;
    chk_pin("back_pressure", 48'(bp), 48'(back_pressure));
    chk_reg(MPF_OFS_FLOW, {29'h0, t[8], t[7], bp});
    @(posedge core_clk);
    rx_frame_end <= 1'b1;
    @(posedge core_clk);
    rx_frame_end <= 1'b0;
    #1;
    chk_pin("status", 48'h1, 48'(rx_status_valid));
    chk_pin("filter", 48'(t[1]), 48'(rx_pkt_filter));
    chk_pin("apply", 48'(t[0]), 48'(rx_pause_apply));
    if (t[0])
      chk_pin("quanta", 48'h40 + 48'(i), 48'(rx_pause_quanta));
    @(posedge core_clk);
    full_duplex <= 1'b1;
    repeat (2) @(posedge core_clk);
  endtask
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial
  begin
    {nrst, reg_wr, reg_rd, tx_ctrl_done, rx_frame_end, rx_is_pause} = 6'h00;
    {rx_frame_ok, rx_filter_force, rx_addr_pass} = 3'h0;
    full_duplex = 1'b1;
    reg_addr = 12'h000;
    reg_wdata = 32'h0000_0000;
    rx_pause_field = 16'h0000;
    err_count = 0;
    checked = 0;
    cycles = 0;
    rx_tab = '{9'h1CF, 9'h0CD, 9'h14E, 9'h18E, 9'h1ED, 9'h052};
    repeat (2) @(posedge core_clk);
    nrst <= 1'b1;
    repeat (3) @(posedge core_clk);
    chk_reg(MPF_OFS_CMD, 32'h0);
    chk_reg(MPF_OFS_DATA, 32'h0);
    chk_reg(MPF_OFS_FLOW, 32'h0);
    chk_reg(12'h120, 32'h0);
    bus_wr(MPF_OFS_DATA, 32'hFFFF_1234);
    chk_reg(MPF_OFS_DATA, 32'h0000_1234);
    phy_cmd(5'h05, 1'b1);
    chk_reg(MPF_OFS_CMD, 32'h0000_0943);
    chk_pin("mdio_oe", 48'h1, 48'(mdio_oe));
    // one mdc high phase spans the half period set at the instance
    @(posedge mdc);
    n_hi = 0;
    while (mdc === 1'b1 && n_hi < 50)
    begin
      @(posedge core_clk);
      #1;
      n_hi++;
    end
    chk_pin("mdc high", 48'h5, 48'(n_hi));
    wait_idle();
    chk_pin("phy word", 48'h1234, 48'(phy.mem[5]));
    chk_pin("phy addr", 48'h1, 48'(phy_addr));
    chk_pin("phy op", 48'h1, 48'(phy_wr));
    chk_pin("mdio_oe", 48'h0, 48'(mdio_oe));
    chk_pin("mdc idle", 48'h0, 48'(mdc));
    for (int k = 0; k < 2; k++)
    begin
      phy_cmd(k ? 5'h09 : 5'h05, 1'b0);
      wait_idle();
      chk_pin("phy op", 48'h0, 48'(phy_wr));
      chk_reg(MPF_OFS_DATA, k ? 32'h0000_C009 : 32'h0000_1234);
    end
    bus_wr(MPF_OFS_FLOW, 32'h00C8_0005);
    #1;
    chk_pin("tx req", 48'h1, 48'(tx_ctrl_req));
    chk_pin("tx time", 48'h00C8, 48'(tx_ctrl_time));
    chk_pin("tx dest", 48'h0180C2000001, tx_ctrl_dest);
    chk_pin("tx type", 48'h8808, 48'(tx_ctrl_type));
    chk_pin("tx opcode", 48'h0001, 48'(tx_ctrl_opcode));
    // a write while busy must not disturb the frame in flight
    bus_wr(MPF_OFS_FLOW, 32'h0001_0004);
    chk_reg(MPF_OFS_FLOW, 32'h00C8_0005);
    @(posedge core_clk);
    tx_ctrl_done <= 1'b1;
    @(posedge core_clk);
    tx_ctrl_done <= 1'b0;
    #1;
    chk_pin("tx req", 48'h0, 48'(tx_ctrl_req));
    chk_reg(MPF_OFS_FLOW, 32'h00C8_0004);
    for (int i = 0; i < 6; i++)
      rx_case(rx_tab[i], i);
    close_out();
  end
endmodule
`default_nettype wire
